// *** ckm_top.sv ***
// Control and output source selection of the programmable clock manager.
`timescale 1ns/1ps
`default_nettype none
`include "ckm_regs.svh"

module ckm_top #(
    parameter int DIV_MAX = 64
) (
    // Clock and reset
    input  wire logic        sys_clk_i,
    input  wire logic        rst_i,
    // Chip-wide set/reset and configuration status
    input  wire logic        global_set_reset_low_n_i,
    input  wire logic        config_done_i,
    // Configuration register port
    input  wire logic        cfg_wr_i,
    input  wire logic [2:0]  cfg_addr_i,
    input  wire logic [7:0]  cfg_wdata_i,
    output logic      [7:0]  cfg_rdata_o,
    output logic             cfg_rdata_oe_o,
    // Clock sources, sampled as levels
    input  wire logic        ref_clk_in_i,
    input  wire logic        loop_clk_in_i,
    input  wire logic        tap_clk_in_i,
    input  wire logic        loop_lock_i,
    // Analog loop control
    output logic             analog_pwr_o,
    output logic             loop_rst_o,
    output logic             pll_mode_o,
    output logic             lock_o,
    // Clock outputs and status
    output logic             fast_io_clock_o,
    output logic             sys_clk_out_o,
    output logic      [1:0]  io_src_o,
    output logic      [1:0]  sys_src_o,
    output logic signed [11:0] phase_qdeg_o
);
    ckm_pkg::ckm_top_st_t st_ff;
    ckm_pkg::ckm_top_st_t nxt_st;

    ckm_core_if core ();

    ckm_divider u_divider (
        .sys_clk_i (sys_clk_i),
        .rst_i     (rst_i),
        .core      (core.div)
    );

    ckm_phase u_phase (
        .sys_clk_i (sys_clk_i),
        .rst_i     (rst_i),
        .core      (core.phase)
    );

    logic            mgr_rst;
    logic            cfg_gate;
    logic            pwr_req;
    logic            loop_ok;
    ckm_pkg::ckm_src_t io_src;
    ckm_pkg::ckm_src_t sys_src;

    // Reads of unmapped indices return zero; reserved bits are never stored.
    function automatic logic [7:0] reg_read(input ckm_pkg::ckm_top_st_t s,
                                            input logic [2:0] a);
        case (a)
            `CKM_IDX_DIVIDER: reg_read = s.divider;
            `CKM_IDX_DELAY:   reg_read = s.delay;
            `CKM_IDX_MODE:    reg_read = s.mode;
            `CKM_IDX_SRC_SEL: reg_read = s.src_sel;
            `CKM_IDX_CONTROL: reg_read = s.control;
            default:          reg_read = 8'h00;
        endcase
    endfunction : reg_read

    function automatic logic src_pick(input ckm_pkg::ckm_src_t sel,
                                      input logic bypass,
                                      input logic loop,
                                      input logic tap,
                                      input logic divided);
        case (sel)
            ckm_pkg::CKM_SRC_BYPASS:  src_pick = bypass;
            ckm_pkg::CKM_SRC_LOOP:    src_pick = loop;
            ckm_pkg::CKM_SRC_TAP:     src_pick = tap;
            ckm_pkg::CKM_SRC_DIVIDED: src_pick = divided;
            default:                  src_pick = 1'b0;
        endcase
    endfunction : src_pick

    // The chip-wide set/reset reaches the manager only while bit 7 is clear.
    assign mgr_rst = st_ff.control[`CKM_CTL_ALL_RST_BIT]
                   | (!global_set_reset_low_n_i
                      && !st_ff.control[`CKM_CTL_GSR_OFF_BIT]);

    // Before configuration completes the manager only runs when bit 6 allows it.
    assign cfg_gate = config_done_i || st_ff.control[`CKM_CTL_CFG_RUN_BIT];

    assign pwr_req = st_ff.control[`CKM_CTL_PWR_BIT] && cfg_gate;

    assign loop_ok = (st_ff.state == ckm_pkg::CKM_ST_RUN)
                   && !st_ff.control[`CKM_CTL_DLL_RST_BIT];

    assign io_src  = ckm_pkg::ckm_src_t'(st_ff.src_sel[`CKM_SRC_IO_LSB +: 2]);
    assign sys_src = ckm_pkg::ckm_src_t'(st_ff.src_sel[`CKM_SRC_SYS_LSB +: 2]);

    // Divider only feeds the fast I/O path; it clears on a full manager reset.
    assign core.div_clk_in    = tap_clk_in_i;
    assign core.div_ratio     = st_ff.divider[5:0];
    assign core.div_clear     = mgr_rst || !pwr_req;
    assign core.delay_setting = st_ff.delay[4:0];

    always_comb begin
        nxt_st = st_ff;

        // Register writes from the configuration port are taken at any time.
        if (cfg_wr_i) begin
            case (cfg_addr_i)
                `CKM_IDX_DIVIDER: nxt_st.divider = cfg_wdata_i & `CKM_DIV_MASK;
                `CKM_IDX_DELAY:   nxt_st.delay   = cfg_wdata_i & `CKM_DELAY_MASK;
                `CKM_IDX_MODE:    nxt_st.mode    = cfg_wdata_i & `CKM_MODE_MASK;
                `CKM_IDX_SRC_SEL: nxt_st.src_sel = cfg_wdata_i & `CKM_SRC_MASK;
                `CKM_IDX_CONTROL: nxt_st.control = cfg_wdata_i & `CKM_CTL_MASK;
                default: begin
                end
            endcase
        end

        case (st_ff.state)
            ckm_pkg::CKM_ST_OFF: begin
                if (pwr_req && mgr_rst) begin
                    nxt_st.state = ckm_pkg::CKM_ST_HELD;
                end else if (pwr_req) begin
                    nxt_st.state = ckm_pkg::CKM_ST_RUN;
                end
            end
            ckm_pkg::CKM_ST_HELD: begin
                if (!pwr_req) begin
                    nxt_st.state = ckm_pkg::CKM_ST_OFF;
                end else if (!mgr_rst) begin
                    nxt_st.state = ckm_pkg::CKM_ST_RUN;
                end
            end
            ckm_pkg::CKM_ST_RUN: begin
                if (!pwr_req) begin
                    nxt_st.state = ckm_pkg::CKM_ST_OFF;
                end else if (mgr_rst) begin
                    nxt_st.state = ckm_pkg::CKM_ST_HELD;
                end
            end
            default: begin
                nxt_st.state = ckm_pkg::CKM_ST_OFF;
            end
        endcase

        nxt_st.analog_pwr = pwr_req;
        nxt_st.loop_rst   = mgr_rst || st_ff.control[`CKM_CTL_DLL_RST_BIT];

        // Lock is only reported by a running, unreset loop outside the config hold.
        nxt_st.lock = loop_ok && pwr_req && loop_lock_i;

        // Bypass needs no analog supply, so it survives power-off but not reset.
        if (mgr_rst) begin
            nxt_st.io_clk  = 1'b0;
            nxt_st.sys_clk = 1'b0;
        end else begin
            nxt_st.io_clk  = src_pick(io_src, ref_clk_in_i,
                                      loop_ok && loop_clk_in_i,
                                      loop_ok && tap_clk_in_i,
                                      loop_ok && core.div_clk_out);
            nxt_st.sys_clk = (sys_src == ckm_pkg::CKM_SRC_DIVIDED) ? 1'b0 :
                             src_pick(sys_src, ref_clk_in_i,
                                      loop_ok && loop_clk_in_i,
                                      loop_ok && tap_clk_in_i,
                                      1'b0);
        end

        // The output data bus floats while configuration holds the manager off.
        nxt_st.rdata_oe = cfg_gate;
        nxt_st.rdata    = reg_read(st_ff, cfg_addr_i);
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            st_ff            <= '0;
            st_ff.src_sel    <= `CKM_RST_SRC_SEL;
            st_ff.control    <= `CKM_RST_CONTROL;
            st_ff.mode       <= `CKM_RST_MODE;
            st_ff.delay      <= `CKM_RST_DELAY;
            st_ff.divider    <= `CKM_RST_DIVIDER;
            st_ff.state      <= ckm_pkg::CKM_ST_OFF;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign cfg_rdata_o     = st_ff.rdata;
    assign cfg_rdata_oe_o  = st_ff.rdata_oe;
    assign analog_pwr_o    = st_ff.analog_pwr;
    assign loop_rst_o      = st_ff.loop_rst;
    assign pll_mode_o      = st_ff.mode[`CKM_MODE_PLL_BIT];
    assign lock_o          = st_ff.lock;
    assign fast_io_clock_o = st_ff.io_clk;
    assign sys_clk_out_o   = st_ff.sys_clk;
    assign io_src_o        = st_ff.src_sel[`CKM_SRC_IO_LSB +: 2];
    assign sys_src_o       = st_ff.src_sel[`CKM_SRC_SYS_LSB +: 2];
    assign phase_qdeg_o    = core.phase_qdeg;

endmodule : ckm_top

`default_nettype wire

// *** ckm_regs.svh ***
// Register indices, field positions, reset values and phase constants of the clock manager.
`ifndef CKM_REGS_SVH
`define CKM_REGS_SVH

`define CKM_ADDR_W          3
`define CKM_IDX_DIVIDER     3'h2
`define CKM_IDX_DELAY       3'h3
`define CKM_IDX_MODE        3'h5
`define CKM_IDX_SRC_SEL     3'h6
`define CKM_IDX_CONTROL     3'h7

`define CKM_SRC_IO_LSB      4
`define CKM_SRC_SYS_LSB     6
`define CKM_MODE_PLL_BIT    0
`define CKM_MODE_MASK       8'h15
`define CKM_CTL_PWR_BIT     0
`define CKM_CTL_ALL_RST_BIT 1
`define CKM_CTL_DLL_RST_BIT 2
`define CKM_CTL_CFG_RUN_BIT 6
`define CKM_CTL_GSR_OFF_BIT 7
`define CKM_CTL_MASK        8'hc7
`define CKM_SRC_MASK        8'hf0
`define CKM_DELAY_MASK      8'h1f
`define CKM_DIV_MASK        8'h3f

`define CKM_RST_SRC_SEL     8'h00
`define CKM_RST_CONTROL     8'h00
`define CKM_RST_MODE        8'h00
`define CKM_RST_DELAY       8'h00
`define CKM_RST_DIVIDER     8'h00

`define CKM_DELAY_WRAP      5'h10
`define CKM_QDEG_PER_STEP   12'h02d
`define CKM_QDEG_FULL_TURN  12'h5a0

`endif

// *** ckm_pkg.sv ***
// Types shared by the clock manager control modules.
package ckm_pkg;

    typedef enum logic [1:0] {
        CKM_SRC_BYPASS,
        CKM_SRC_LOOP,
        CKM_SRC_TAP,
        CKM_SRC_DIVIDED
    } ckm_src_t;

    typedef enum logic [1:0] {
        CKM_ST_OFF,
        CKM_ST_HELD,
        CKM_ST_RUN
    } ckm_state_t;

    typedef struct packed {
        logic [7:0] src_sel;
        logic [7:0] control;
        logic [7:0] mode;
        logic [7:0] delay;
        logic [7:0] divider;
        ckm_state_t state;
        logic       analog_pwr;
        logic       loop_rst;
        logic       lock;
        logic       io_clk;
        logic       sys_clk;
        logic       rdata_oe;
        logic [7:0] rdata;
    } ckm_top_st_t;

    typedef struct packed {
        logic [5:0] cnt;
        logic       in_d;
        logic       out;
    } ckm_div_st_t;

    typedef struct packed {
        logic signed [11:0] phase;
    } ckm_phase_st_t;

endpackage : ckm_pkg

// *** ckm_core_if.sv ***
// Carrier between the clock manager top and its divider and phase calculator.
`timescale 1ns/1ps
`default_nettype none

interface ckm_core_if;
    logic               div_clk_in;
    logic [5:0]         div_ratio;
    logic               div_clear;
    logic               div_clk_out;
    logic [4:0]         delay_setting;
    logic signed [11:0] phase_qdeg;

    modport top (
        output div_clk_in,
        output div_ratio,
        output div_clear,
        input  div_clk_out,
        output delay_setting,
        input  phase_qdeg
    );
    modport div (
        input  div_clk_in,
        input  div_ratio,
        input  div_clear,
        output div_clk_out
    );
    modport phase (
        input  delay_setting,
        output phase_qdeg
    );
endinterface : ckm_core_if

`default_nettype wire

// *** ckm_divider.sv ***
// Output stage divider on the delay-line path towards the fast I/O clock.
`timescale 1ns/1ps
`default_nettype none

module ckm_divider (
    // Clock and reset
    input  wire logic   sys_clk_i,
    input  wire logic   rst_i,
    // Carrier
    ckm_core_if.div     core
);
    ckm_pkg::ckm_div_st_t st_ff;
    ckm_pkg::ckm_div_st_t nxt_st;

    // The ratio field holds divide-by minus one, so 1 to 64 are reachable.
    always_comb begin
        nxt_st      = st_ff;
        nxt_st.in_d = core.div_clk_in;
        if (core.div_clear) begin
            nxt_st = '0;
        end else if (core.div_ratio == 6'h00) begin
            nxt_st.out = core.div_clk_in;
        end else begin
            if (core.div_clk_in && !st_ff.in_d) begin
                nxt_st.cnt = (st_ff.cnt == core.div_ratio) ? 6'h00 : st_ff.cnt + 6'h01;
            end
            nxt_st.out = (nxt_st.cnt < ((core.div_ratio >> 1) + 6'h01));
        end
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign core.div_clk_out = st_ff.out;
endmodule : ckm_divider

`default_nettype wire

// *** ckm_phase.sv ***
// Phase shift of the delay-locked output, in quarter degrees.
`timescale 1ns/1ps
`default_nettype none
`include "ckm_regs.svh"

module ckm_phase (
    // Clock and reset
    input  wire logic   sys_clk_i,
    input  wire logic   rst_i,
    // Carrier
    ckm_core_if.phase   core
);
    ckm_pkg::ckm_phase_st_t st_ff;
    ckm_pkg::ckm_phase_st_t nxt_st;

    // Quarter degrees keep the 11.25 degree step exact in integer form.
    function automatic logic signed [11:0] qdeg_of(input logic [4:0] d);
        logic [11:0] prod;
        prod = 12'(d) * `CKM_QDEG_PER_STEP;
        if (d < `CKM_DELAY_WRAP) begin
            qdeg_of = signed'(prod);
        end else begin
            qdeg_of = signed'(prod - `CKM_QDEG_FULL_TURN);
        end
    endfunction : qdeg_of

    always_comb begin
        nxt_st       = st_ff;
        nxt_st.phase = qdeg_of(core.delay_setting);
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign core.phase_qdeg = st_ff.phase;
endmodule : ckm_phase

`default_nettype wire

// *** ckm_src_model.sv ***
// Model of the loop, delay line and bypass clocks that feed the clock manager.
`timescale 1ns/1ps
`default_nettype none

module ckm_src_model (
    // Clock and reset
    input  wire logic sys_clk_i,
    input  wire logic rst_i,
    // Lock request from the bench
    input  wire logic lock_en_i,
    // Clock levels and raw lock
    output logic      ref_clk_o,
    output logic      loop_clk_o,
    output logic      tap_clk_o,
    output logic      loop_lock_o
);
    logic [1:0] ref_cnt_ff;
    logic [1:0] loop_cnt_ff;

    // Only half-duty clocks are offered, so the divider never sees a duty-adjusted input.
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            ref_cnt_ff  <= 2'h0;
            loop_cnt_ff <= 2'h0;
            ref_clk_o   <= 1'b0;
            loop_clk_o  <= 1'b0;
            tap_clk_o   <= 1'b0;
            loop_lock_o <= 1'b0;
        end else begin
            ref_cnt_ff  <= ref_cnt_ff + 2'h1;
            loop_cnt_ff <= (loop_cnt_ff == 2'h2) ? 2'h0 : loop_cnt_ff + 2'h1;
            ref_clk_o   <= ref_clk_o ^ ref_cnt_ff[0];
            loop_clk_o  <= loop_clk_o ^ (loop_cnt_ff == 2'h2);
            tap_clk_o   <= ~tap_clk_o;
            loop_lock_o <= lock_en_i;
        end
    end
endmodule : ckm_src_model

`default_nettype wire

// *** ckm_top_monitor.sv ***
// Port-level assertions of the clock manager top.
`timescale 1ns/1ps
`default_nettype none
`include "ckm_regs.svh"

module ckm_mon #(
    parameter int DIV_MAX = 64
) (
    // Clock, reset and inputs
    input wire logic               sys_clk_i,
    input wire logic               rst_i,
    input wire logic               config_done_i,
    input wire logic               cfg_wr_i,
    input wire logic [2:0]         cfg_addr_i,
    input wire logic [7:0]         cfg_wdata_i,
    input wire logic               ref_clk_in_i,
    input wire logic               loop_lock_i,
    // Outputs under watch
    input wire logic [7:0]         cfg_rdata_o,
    input wire logic               cfg_rdata_oe_o,
    input wire logic               analog_pwr_o,
    input wire logic               pll_mode_o,
    input wire logic               lock_o,
    input wire logic               fast_io_clock_o,
    input wire logic               sys_clk_out_o,
    input wire logic [1:0]         io_src_o,
    input wire logic [1:0]         sys_src_o,
    input wire logic signed [11:0] phase_qdeg_o
);
    default clocking dc @(posedge sys_clk_i);
    endclocking
    default disable iff (rst_i);

    sequence src_wr_s;
        cfg_wr_i && cfg_addr_i == `CKM_IDX_SRC_SEL;
    endsequence
    sequence src_hold_s;
        !cfg_wr_i && cfg_addr_i == `CKM_IDX_SRC_SEL;
    endsequence

    src_fields_a: assert property (src_wr_s |=> io_src_o == $past(cfg_wdata_i[5:4])
        && sys_src_o == $past(cfg_wdata_i[7:6])) else $error("source fields not loaded");
    src_mask_a: assert property (src_wr_s ##1 src_hold_s |=> !cfg_rdata_oe_o
        || cfg_rdata_o == ($past(cfg_wdata_i, 2) & `CKM_SRC_MASK)) else $error("bad readback");
    rst_dflt_a: assert property ($fell(rst_i) |=> !pll_mode_o && io_src_o == 2'h0
        && sys_src_o == 2'h0) else $error("register defaults wrong");
    oe_done_a: assert property (config_done_i |=> cfg_rdata_oe_o)
        else $error("bus not driven after done");
    dark_cfg_a: assert property (!cfg_rdata_oe_o [*3] |-> !analog_pwr_o && !lock_o)
        else $error("power or lock during configuration");
    lock_raw_a: assert property (lock_o |-> $past(loop_lock_i))
        else $error("lock without raw lock");
    io_byp_a: assert property (io_src_o == 2'h0 |=> !fast_io_clock_o || $past(ref_clk_in_i))
        else $error("bypass level wrong");
    sys_resv_a: assert property (sys_src_o == 2'h3 |=> !sys_clk_out_o)
        else $error("reserved source active");
    loop_dark_a: assert property ((io_src_o == 2'h1 && !analog_pwr_o) [*2] |=> !fast_io_clock_o)
        else $error("loop clock without power");
    phase_grid_a: assert property (phase_qdeg_o >= -12'sd720 && phase_qdeg_o <= 12'sd675
        && phase_qdeg_o % 45 == 0) else $error("phase off grid");
endmodule : ckm_mon

bind ckm_top ckm_mon #(.DIV_MAX(DIV_MAX)) i_ckm_mon (
    .sys_clk_i, .rst_i, .config_done_i, .cfg_wr_i, .cfg_addr_i, .cfg_wdata_i, .ref_clk_in_i,
    .loop_lock_i, .cfg_rdata_o, .cfg_rdata_oe_o, .analog_pwr_o, .pll_mode_o, .lock_o,
    .fast_io_clock_o, .sys_clk_out_o, .io_src_o, .sys_src_o, .phase_qdeg_o
);

`default_nettype wire

// *** ckm_top_tb.sv ***
// Self-checking bench of the clock manager control block.
`timescale 1ns/1ps
`default_nettype none

module ckm_top_tb;
    typedef struct packed {
        logic       w;
        logic [2:0] a;
        logic [7:0] d;
        logic [2:0] r;
        logic [7:0] e;
    } ckm_row_t;

    logic               sys_clk_i = 1'b0;
    logic               rst_i = 1'b1;
    logic               global_set_reset_low_n_i = 1'b1;
    logic               config_done_i = 1'b0;
    logic               cfg_wr_i = 1'b0;
    logic [2:0]         cfg_addr_i = 3'h0;
    logic [7:0]         cfg_wdata_i = 8'h00;
    logic               lock_en = 1'b0;
    logic               ref_clk_in_i, loop_clk_in_i, tap_clk_in_i, loop_lock_i;
    logic [7:0]         cfg_rdata_o;
    logic               cfg_rdata_oe_o, analog_pwr_o, loop_rst_o, pll_mode_o, lock_o;
    logic               fast_io_clock_o, sys_clk_out_o;
    logic [1:0]         io_src_o, sys_src_o;
    logic signed [11:0] phase_qdeg_o;
    logic [7:0]         ratios [2] = '{8'h02, 8'h3f};
    logic [7:0]         delays [4] = '{8'h00, 8'h0f, 8'h10, 8'h1f};
    int                 failures = 0;
    int                 comparisons = 0;
    int                 per, highs;
    ckm_row_t           rows [11] = '{
        '{1'b0, 3'h2, 8'h00, 3'h2, 8'h00}, '{1'b0, 3'h3, 8'h00, 3'h3, 8'h00},
        '{1'b0, 3'h5, 8'h00, 3'h5, 8'h00}, '{1'b0, 3'h6, 8'h00, 3'h6, 8'h00},
        '{1'b0, 3'h7, 8'h00, 3'h7, 8'h00}, '{1'b1, 3'h6, 8'hff, 3'h6, 8'hf0},
        '{1'b1, 3'h5, 8'hff, 3'h5, 8'h15}, '{1'b1, 3'h3, 8'hff, 3'h3, 8'h1f},
        '{1'b1, 3'h2, 8'hff, 3'h2, 8'h3f}, '{1'b1, 3'h7, 8'hff, 3'h7, 8'hc7},
        '{1'b1, 3'h1, 8'h00, 3'h6, 8'hf0}};

    always #50 sys_clk_i = ~sys_clk_i;

    ckm_top #(.DIV_MAX(64)) i_ckm_top (
        .sys_clk_i, .rst_i, .global_set_reset_low_n_i, .config_done_i, .cfg_wr_i, .cfg_addr_i,
        .cfg_wdata_i, .cfg_rdata_o, .cfg_rdata_oe_o, .ref_clk_in_i, .loop_clk_in_i, .tap_clk_in_i,
        .loop_lock_i, .analog_pwr_o, .loop_rst_o, .pll_mode_o, .lock_o, .fast_io_clock_o,
        .sys_clk_out_o, .io_src_o, .sys_src_o, .phase_qdeg_o
    );
    ckm_src_model i_ckm_src_model (
        .sys_clk_i, .rst_i, .lock_en_i(lock_en), .ref_clk_o(ref_clk_in_i),
        .loop_clk_o(loop_clk_in_i), .tap_clk_o(tap_clk_in_i), .loop_lock_o(loop_lock_i)
    );

    task automatic test_done();
        if (failures == 0 && comparisons > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : test_done

    task automatic chk_bit(input logic got, input logic exp, input string msg);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED %0t %s", $time, msg);
        end
    endtask : chk_bit

    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED %0t read %h expected %h", $time, got, exp);
        end
    endtask : chk_byte

    task automatic chk_word(input logic [11:0] got, input logic [11:0] exp, input string msg);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED %0t %s %h expected %h", $time, msg, got, exp);
        end
    endtask : chk_word

    task automatic wt(input int n);
        repeat (n) @(posedge sys_clk_i);
        #1;
    endtask : wt

    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge sys_clk_i);
        cfg_wr_i    <= 1'b1;
        cfg_addr_i  <= a;
        cfg_wdata_i <= d;
        @(posedge sys_clk_i);
        cfg_wr_i    <= 1'b0;
    endtask : wr

    task automatic rd_chk(input logic [2:0] a, input logic [7:0] e);
        @(posedge sys_clk_i);
        cfg_addr_i <= a;
        wt(2);
        chk_byte(cfg_rdata_o, e);
    endtask : rd_chk

    // The source level is taken before the edge's updates land, as the design samples it.
    task automatic follow(input logic [1:0] s, input logic on_io, input logic zero);
        logic v;
        repeat (8) begin
            @(posedge sys_clk_i);
            v = zero ? 1'b0 : (s == 2'h0) ? ref_clk_in_i : (s == 2'h1) ? loop_clk_in_i : tap_clk_in_i;
            #1;
            chk_bit(on_io ? fast_io_clock_o : sys_clk_out_o, v, "clock output level");
        end
    endtask : follow

    initial begin
        repeat (20000) @(posedge sys_clk_i);
        failures++;
        test_done();
    end

    initial begin
        repeat (12) @(posedge sys_clk_i);
        rst_i         <= 1'b0;
        lock_en       <= 1'b1;
        config_done_i <= 1'b1;
        wt(2);
        foreach (rows[i]) begin
            if (rows[i].w)
                wr(rows[i].a, rows[i].d);
            rd_chk(rows[i].r, rows[i].e);
        end
        wr(3'h7, 8'h01);
        wr(3'h6, 8'h50);
        wr(3'h5, 8'h00);
        config_done_i <= 1'b0;
        wt(4);
        chk_bit(analog_pwr_o, 1'b0, "power during configuration");
        chk_bit(cfg_rdata_oe_o, 1'b0, "bus driven during configuration");
        chk_bit(lock_o, 1'b0, "lock during configuration");
        wr(3'h7, 8'h41);
        wt(4);
        chk_bit(analog_pwr_o, 1'b1, "no power with run enable");
        chk_bit(lock_o, 1'b1, "no lock with run enable");
        chk_bit(loop_rst_o, 1'b0, "loop reset while running");
        @(posedge sys_clk_i);
        config_done_i <= 1'b1;
        wr(3'h7, 8'h00);
        wt(2);
        chk_bit(analog_pwr_o, 1'b0, "power not off");
        wr(3'h7, 8'h01);
        wr(3'h5, 8'h01);
        wt(4);
        chk_bit(analog_pwr_o, 1'b1, "power not on");
        chk_bit(pll_mode_o, 1'b1, "mode bit");
        for (int s = 0; s < 4; s++) begin
            wr(3'h6, {s[1:0], s[1:0], 4'h0});
            if (s < 3)
                follow(s[1:0], 1'b1, 1'b0);
            follow(s[1:0], 1'b0, s == 3);
        end
        wr(3'h6, 8'h30);
        foreach (ratios[k]) begin
            wr(3'h2, ratios[k]);
            wt(130);
            per   = 2 * (int'(ratios[k]) + 1);
            highs = 0;
            repeat (per * (256 / per)) begin
                wt(1);
                highs += int'(fast_io_clock_o === 1'b1);
            end
            chk_word(12'(highs), 12'(2 * ((ratios[k] >> 1) + 1) * (256 / per)), "duty");
        end
        wr(3'h6, 8'h10);
        wr(3'h7, 8'h05);
        wt(2);
        chk_bit(loop_rst_o, 1'b1, "no loop reset");
        follow(2'h1, 1'b1, 1'b1);
        follow(2'h0, 1'b0, 1'b0);
        chk_bit(lock_o, 1'b0, "lock during loop reset");
        rd_chk(3'h2, 8'h3f);
        wr(3'h7, 8'h03);
        wt(2);
        chk_bit(loop_rst_o, 1'b1, "no manager reset");
        follow(2'h0, 1'b0, 1'b1);
        rd_chk(3'h2, 8'h3f);
        wr(3'h7, 8'h01);
        global_set_reset_low_n_i <= 1'b0;
        wt(2);
        chk_bit(loop_rst_o, 1'b1, "set/reset ignored");
        follow(2'h0, 1'b0, 1'b1);
        wr(3'h7, 8'h81);
        wt(2);
        chk_bit(loop_rst_o, 1'b0, "set/reset not masked");
        follow(2'h0, 1'b0, 1'b0);
        @(posedge sys_clk_i);
        global_set_reset_low_n_i <= 1'b1;
        foreach (delays[k]) begin
            wr(3'h3, delays[k]);
            wt(2);
            chk_word(phase_qdeg_o, 12'(delays[k] < 16 ? 45 * delays[k] : 45 * delays[k] - 1440), "phase");
        end
        @(posedge sys_clk_i);
        rst_i <= 1'b1;
        wt(2);
        @(posedge sys_clk_i);
        rst_i <= 1'b0;
        rd_chk(3'h6, 8'h00);
        chk_bit(analog_pwr_o, 1'b0, "power after reset");
        chk_bit(pll_mode_o, 1'b0, "mode after reset");
        test_done();
    end
endmodule : ckm_top_tb

`default_nettype wire
